// *** rtl/scan_seq_map.svh ***
`ifndef SCAN_SEQ_MAP_SVH
`define SCAN_SEQ_MAP_SVH

// ----------------------------------------------------------------------------
// Register offsets (byte addresses).
// ----------------------------------------------------------------------------
`define REG_CTRL        12'h000
`define REG_CFG         12'h004
`define REG_TIMER       12'h008
`define REG_DELAY       12'h00C
`define REG_CYCLES      12'h010
`define REG_STATUS      12'h014
`define REG_LAST_RD     12'h018
`define REG_RD_COUNT    12'h01C
`define REG_RD_ADDR     12'h020
`define REG_RD_DATA     12'h024

// ----------------------------------------------------------------------------
// Field positions.
// ----------------------------------------------------------------------------
`define CTRL_START_BIT  0
`define CTRL_HALT_BIT   1
`define CTRL_MTRIG_BIT  2
`define CFG_SRC_LSB     0
`define CFG_EXT_BIT     2
`define CFG_DLY_BIT     3
`define CFG_CNT_LSB     16

// ----------------------------------------------------------------------------
// Reset values and limits.
// ----------------------------------------------------------------------------
`define CNT_MAX         10'h3FF
`define CNT_RESET       10'h001
`define CYCLES_RESET    16'h0001
`define BUF_DEPTH       1024
`define BUF_AW          10

`endif

// *** rtl/scan_seq_pkg.sv ***
package scan_seq_pkg;

  // Control source selection.
  typedef enum logic [1:0] {
    SRC_IMMEDIATE = 2'b00,
    SRC_TIMER     = 2'b01,
    SRC_EXTERNAL  = 2'b10
  } ctrl_src_t;

  // Sequencer states.
  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_ARM     = 3'b001,
    ST_DELAY   = 3'b010,
    ST_MEASURE = 3'b011,
    ST_OUTTRIG = 3'b100
  } seq_state_t;

  // Measurement handshake toward the converter.
  typedef struct packed {
    logic        req;
    logic        chan2;
  } meas_req_t;

  typedef struct packed {
    logic        done;
    logic [31:0] value;
  } meas_rsp_t;

endpackage

// *** rtl/reading_buffer.sv ***
`timescale 1ns/10ps

`include "scan_seq_map.svh"

// Reading store: one write port and one read port, 1024 words.
module reading_buffer
  import scan_seq_pkg::*;
(
  input  wire logic                hclk,
  input  wire logic                we,
  input  wire logic [`BUF_AW-1:0]  waddr,
  input  wire logic [31:0]         wdata,
  input  wire logic [`BUF_AW-1:0]  raddr,
  output logic      [31:0]         rdata
);

  logic [31:0] mem [0:`BUF_DEPTH-1];

  // Registered write and read.
  always_ff @(posedge hclk)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end

endmodule

// *** rtl/scan_trigger_sequencer.sv ***
// Chosen here: register access over AHB-Lite and the address map.
`timescale 1ns/10ps

`include "scan_seq_map.svh"

module scan_trigger_sequencer
  import scan_seq_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [11:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        ext_trigger_in,
  output meas_req_t        meas_req,
  input  wire meas_rsp_t   meas_rsp,
  output logic             out_trigger,
  output logic             chan1_indicator,
  output logic             chan2_indicator,
  output logic             scan_active
);

  // --------------------------------------------------------------------------
  // Configuration registers
  // --------------------------------------------------------------------------
  ctrl_src_t   src_q;
  logic        ext_mode_q;
  logic        dly_en_q;
  logic [9:0]  primary_channel_count_q;
  logic [31:0] timer_term_q;
  logic [31:0] delay_term_q;
  logic [15:0] cycles_q;
  logic        start_q;
  logic        halt_q;
  logic        manual_trigger_request_q;

  // Address phase capture.
  logic        wr_pend_q;
  logic [11:0] addr_q;
  logic        take;
  assign take = hsel & hready & htrans[1];

  // Sequencer state.
  seq_state_t  state_q;
  logic [10:0] samples_q;
  logic [15:0] manual_trigger_request_left_q;
  logic [31:0] timer_cnt_q;
  logic        timer_exp_q;
  logic [31:0] delay_cnt_q;
  logic [`BUF_AW-1:0] wr_ptr_q;
  logic [10:0] stored_q;
  logic [31:0] last_rd_q;
  logic [`BUF_AW-1:0] rd_addr_q;
  logic [31:0] buf_rdata;
  logic        ext_s1_q;
  logic        ext_s2_q;
  logic        ext_s3_q;
  logic        ext_edge;

  // Clamp the channel-1 count into the legal range of 1 to 1023.
  function automatic logic [9:0] clamp_count(input logic [9:0] v);
    clamp_count = (v == 10'h000) ? `CNT_RESET : v;
  endfunction

  // --------------------------------------------------------------------------
  // AHB-Lite slave
  // --------------------------------------------------------------------------

  // Latch the address phase; zero-wait answers, always OKAY.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_q <= 1'b0;
      addr_q    <= 12'h000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else
    begin
      wr_pend_q <= take & hwrite;
      if (take)
      begin
        addr_q <= haddr;
      end
    end
  end

  // Register writes; command bits are single-cycle pulses.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      src_q                    <= SRC_IMMEDIATE;
      ext_mode_q               <= 1'b0;
      dly_en_q                 <= 1'b0;
      primary_channel_count_q  <= `CNT_RESET;
      timer_term_q             <= 32'h0000_0000;
      delay_term_q             <= 32'h0000_0000;
      cycles_q                 <= `CYCLES_RESET;
      start_q                  <= 1'b0;
      halt_q                   <= 1'b0;
      manual_trigger_request_q <= 1'b0;
      rd_addr_q                <= '0;
    end
    else
    begin
      start_q                  <= 1'b0;
      halt_q                   <= 1'b0;
      manual_trigger_request_q <= 1'b0;
      if (wr_pend_q)
      begin
        unique case (addr_q)
          `REG_CTRL:
          begin
            start_q                  <= hwdata[`CTRL_START_BIT];
            halt_q                   <= hwdata[`CTRL_HALT_BIT];
            manual_trigger_request_q <= hwdata[`CTRL_MTRIG_BIT];
          end
          `REG_CFG:
          begin
            src_q      <= (hwdata[`CFG_SRC_LSB+1:`CFG_SRC_LSB] == 2'b11) ?
                          SRC_EXTERNAL : ctrl_src_t'(hwdata[`CFG_SRC_LSB+1:`CFG_SRC_LSB]);
            ext_mode_q <= hwdata[`CFG_EXT_BIT];
            dly_en_q   <= hwdata[`CFG_DLY_BIT];
            primary_channel_count_q <= clamp_count(hwdata[`CFG_CNT_LSB+9:`CFG_CNT_LSB]);
          end
          `REG_TIMER:   timer_term_q <= hwdata;
          `REG_DELAY:   delay_term_q <= hwdata;
          `REG_CYCLES:  cycles_q     <= (hwdata[15:0] == 16'h0000) ? `CYCLES_RESET
                                                                    : hwdata[15:0];
          `REG_RD_ADDR: rd_addr_q    <= hwdata[`BUF_AW-1:0];
          default:      ;
        endcase
      end
    end
  end

  // Read data is captured at the address phase so that it comes from a flop for the
  // whole data phase; a read issued right behind a write returns the old contents.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hrdata <= 32'h0000_0000;
    end
    else
    begin
      hrdata <= 32'h0000_0000;
      if (take && !hwrite)
      begin
        unique case (haddr)
          `REG_CFG:      hrdata <= {6'h00, primary_channel_count_q, 12'h000,
                                    dly_en_q, ext_mode_q, src_q};
          `REG_TIMER:    hrdata <= timer_term_q;
          `REG_DELAY:    hrdata <= delay_term_q;
          `REG_CYCLES:   hrdata <= {16'h0000, cycles_q};
          `REG_STATUS:   hrdata <= {13'h0000, manual_trigger_request_left_q, state_q};
          `REG_LAST_RD:  hrdata <= last_rd_q;
          `REG_RD_COUNT: hrdata <= {21'h00_0000, stored_q};
          `REG_RD_ADDR:  hrdata <= {22'h00_0000, rd_addr_q};
          `REG_RD_DATA:  hrdata <= buf_rdata;
          default:       hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // --------------------------------------------------------------------------
  // External trigger synchroniser
  // --------------------------------------------------------------------------

  // Two flops, then a third for the rising-edge detector.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ext_s1_q <= 1'b0;
      ext_s2_q <= 1'b0;
      ext_s3_q <= 1'b0;
    end
    else
    begin
      ext_s1_q <= ext_trigger_in;
      ext_s2_q <= ext_s1_q;
      ext_s3_q <= ext_s2_q;
    end
  end
  assign ext_edge = ext_s2_q & ~ext_s3_q;

  // --------------------------------------------------------------------------
  // Interval timer
  // --------------------------------------------------------------------------

  // Restarts on each cycle launch; flags expiry and holds it.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      timer_cnt_q <= 32'h0000_0000;
      timer_exp_q <= 1'b0;
    end
    else if ((start_q && state_q == ST_IDLE) ||
             (state_q == ST_ARM && src_q == SRC_TIMER && timer_exp_q))
    begin
      timer_cnt_q <= 32'h0000_0000;
      timer_exp_q <= (timer_term_q == 32'h0000_0000);
    end
    else if (!timer_exp_q)
    begin
      timer_cnt_q <= timer_cnt_q + 32'h0000_0001;
      timer_exp_q <= (timer_cnt_q + 32'h0000_0001 >= timer_term_q);
    end
  end

  // --------------------------------------------------------------------------
  // Sequencer
  // --------------------------------------------------------------------------

  // Main trigger model state machine.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_q     <= ST_IDLE;
      samples_q   <= 11'h000;
      manual_trigger_request_left_q <= 16'h0000;
      delay_cnt_q <= 32'h0000_0000;
      meas_req    <= '0;
      out_trigger <= 1'b0;
      scan_active <= 1'b0;
    end
    else if (halt_q)
    begin
      state_q     <= ST_IDLE;
      meas_req    <= '0;
      out_trigger <= 1'b0;
      scan_active <= 1'b0;
    end
    else
    begin
      out_trigger  <= 1'b0;
      meas_req.req <= 1'b0;
      unique case (state_q)
        ST_IDLE:
        begin
          if (start_q)
          begin
            manual_trigger_request_left_q <= cycles_q;
            scan_active <= 1'b1;
            samples_q   <= ext_mode_q ? 11'h001 : {1'b0, primary_channel_count_q} + 11'h001;
            delay_cnt_q <= 32'h0000_0000;
            // Immediate and timer pass at once; external waits armed.
            state_q <= (src_q == SRC_EXTERNAL) ? ST_ARM : ST_DELAY;
          end
        end
        ST_ARM:
        begin
          samples_q   <= ext_mode_q ? 11'h001 : {1'b0, primary_channel_count_q} + 11'h001;
          delay_cnt_q <= 32'h0000_0000;
          if ((src_q == SRC_IMMEDIATE) ||
              (src_q == SRC_TIMER && timer_exp_q) ||
              (src_q == SRC_EXTERNAL && (ext_edge || manual_trigger_request_q)))
          begin
            state_q <= ST_DELAY;
          end
        end
        ST_DELAY:
        begin
          if (!dly_en_q || delay_cnt_q >= delay_term_q)
          begin
            state_q        <= ST_MEASURE;
            meas_req.req   <= 1'b1;
            // Channel 2 only on the first sample of an internal cycle.
            meas_req.chan2 <= ~ext_mode_q &&
                              (samples_q == {1'b0, primary_channel_count_q} + 11'h001);
          end
          else
          begin
            delay_cnt_q <= delay_cnt_q + 32'h0000_0001;
          end
        end
        ST_MEASURE:
        begin
          if (meas_rsp.done)
          begin
            samples_q   <= samples_q - 11'h001;
            delay_cnt_q <= 32'h0000_0000;
            if (samples_q == 11'h001)
            begin
              state_q     <= ST_OUTTRIG;
              out_trigger <= 1'b1;
            end
            else
            begin
              state_q <= ST_DELAY;
            end
          end
        end
        ST_OUTTRIG:
        begin
          manual_trigger_request_left_q <= manual_trigger_request_left_q - 16'h0001;
          if (manual_trigger_request_left_q == 16'h0001)
          begin
            state_q     <= ST_IDLE;
            scan_active <= 1'b0;
          end
          else
          begin
            state_q <= ST_ARM;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Channel indicators follow the selected internal channel only.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      chan1_indicator <= 1'b0;
      chan2_indicator <= 1'b0;
    end
    else
    begin
      chan1_indicator <= scan_active & ~ext_mode_q & ~meas_req.chan2;
      chan2_indicator <= scan_active & ~ext_mode_q & meas_req.chan2;
    end
  end

  // --------------------------------------------------------------------------
  // Reading store
  // --------------------------------------------------------------------------

  // Completed measurements are written until 1024 are stored; a new start rewinds the pointer.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_ptr_q  <= '0;
      stored_q  <= 11'h000;
      last_rd_q <= 32'h0000_0000;
    end
    else if (start_q && state_q == ST_IDLE)
    begin
      wr_ptr_q <= '0;
      stored_q <= 11'h000;
    end
    else if (state_q == ST_MEASURE && meas_rsp.done && !halt_q)
    begin
      wr_ptr_q  <= wr_ptr_q + 1'b1;
      last_rd_q <= meas_rsp.value;
      if (stored_q != 11'h400)
      begin
        stored_q <= stored_q + 11'h001;
      end
    end
  end

  reading_buffer u_buf (
    .hclk  (hclk),
    .we    (state_q == ST_MEASURE && meas_rsp.done && !halt_q && stored_q != 11'h400),
    .waddr (wr_ptr_q),
    .wdata (meas_rsp.value),
    .raddr (rd_addr_q),
    .rdata (buf_rdata)
  );

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------

  chk_ext_no_chan2: assert property (@(posedge hclk) disable iff (!hresetn)
    (meas_req.req && ext_mode_q) |-> !meas_req.chan2)
    else $error("channel 2 used in external scan");

  chk_ind_off_ext: assert property (@(posedge hclk) disable iff (!hresetn)
    (ext_mode_q && $past(ext_mode_q)) |-> !chan1_indicator && !chan2_indicator)
    else $error("indicator on during external scan");

  chk_halt_idle: assert property (@(posedge hclk) disable iff (!hresetn)
    halt_q |=> state_q == ST_IDLE && !scan_active)
    else $error("halt did not stop sequencer");

  chk_imm_to_delay: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_q == ST_ARM && src_q == SRC_IMMEDIATE && !halt_q) |=> state_q == ST_DELAY)
    else $error("immediate source did not pass");

  chk_ext_waits: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_q == ST_ARM && src_q == SRC_EXTERNAL && !ext_edge
     && !manual_trigger_request_q) |=> state_q != ST_DELAY)
    else $error("external source passed without trigger");

  chk_timer_waits: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_q == ST_ARM && src_q == SRC_TIMER && !timer_exp_q) |=> state_q != ST_DELAY)
    else $error("timer source passed before expiry");

  chk_one_outtrig: assert property (@(posedge hclk) disable iff (!hresetn)
    out_trigger |=> !out_trigger)
    else $error("output trigger longer than one cycle");

  chk_delay_stall: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_q == ST_DELAY && dly_en_q && delay_cnt_q < delay_term_q && !halt_q)
    |=> state_q == ST_DELAY)
    else $error("delay stage left early");

  chk_final_idle: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_q == ST_OUTTRIG && manual_trigger_request_left_q == 16'h0001 && !halt_q) |=> state_q == ST_IDLE)
    else $error("no idle after final cycle");

endmodule

// *** testbench/scan_partner.sv ***
`timescale 1ns/10ps

// ----------------------------------------------------------------------------
// Converter and switching mainframe seen from the sequencer.
// ----------------------------------------------------------------------------
module scan_partner
  import scan_seq_pkg::*;
(
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire meas_req_t  meas_req,
  input  wire logic [7:0] lat,
  input  wire logic       kick,
  output meas_rsp_t       meas_rsp,
  output logic            ext_trigger_in
);
  logic        busy_q;
  logic        done_q;
  logic        chan2_q;
  logic [7:0]  wait_q;
  logic [15:0] seq_q;
  logic [15:0] cyc_q;
  logic [4:0]  fire_q;

  // The converter answers each request after lat cycles; between answers the value
  // bus wanders so that a stale sample can never pass for a result.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      busy_q <= 1'b0;
      done_q <= 1'b0;
      seq_q  <= 16'h0000;
    end
    else
    begin
      done_q <= 1'b0;
      if (meas_req.req)
      begin
        busy_q  <= 1'b1;
        wait_q  <= lat;
        chan2_q <= meas_req.chan2;
      end
      else if (busy_q && wait_q == 8'h00)
      begin
        busy_q <= 1'b0;
        done_q <= 1'b1;
        seq_q  <= seq_q + 16'h0001;
      end
      else if (busy_q)
        wait_q <= wait_q - 8'h01;
    end
  end

  // Free-running pattern and the mainframe trigger, four cycles after a kick.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cyc_q  <= 16'h0000;
      fire_q <= 5'h00;
    end
    else
    begin
      cyc_q  <= cyc_q + 16'h0001;
      fire_q <= {fire_q[3:0], kick};
    end
  end

  // The result carries the channel in the upper half and the reading index below.
  assign meas_rsp.done  = done_q;
  assign meas_rsp.value = done_q ? {chan2_q ? 16'h0002 : 16'h0001, seq_q - 16'h0001}
                                 : {cyc_q, ~cyc_q};
  assign ext_trigger_in = fire_q[3] | fire_q[4];
endmodule

// *** testbench/testbench.sv ***
`timescale 1ns/10ps

`include "scan_seq_map.svh"

module testbench
  import scan_seq_pkg::*;
;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [11:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hready;
  logic        hresp;
  logic [31:0] hrdata;
  logic        ext_trigger_in;
  meas_req_t   meas_req;
  meas_rsp_t   meas_rsp;
  logic        out_trigger;
  logic        chan1_indicator;
  logic        chan2_indicator;
  logic        scan_active;
  logic [7:0]  lat;
  logic        kick;
  logic        ext_mode;
  logic        q_ch[$];
  int          q_t[$];
  int          q_tt[$];
  int          cyc;
  int          ind_bad;
  int          fail_count;
  int          checks_done;

  scan_trigger_sequencer i_scan_trigger_sequencer (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .ext_trigger_in(ext_trigger_in),
    .meas_req(meas_req), .meas_rsp(meas_rsp), .out_trigger(out_trigger),
    .chan1_indicator(chan1_indicator), .chan2_indicator(chan2_indicator),
    .scan_active(scan_active)
  );

  scan_partner i_scan_partner (
    .hclk(hclk), .hresetn(hresetn), .meas_req(meas_req), .lat(lat), .kick(kick),
    .meas_rsp(meas_rsp), .ext_trigger_in(ext_trigger_in)
  );

  // ----------------------------------------------------------------------------
  // Clock, watchdog and the record of measurements and output triggers.
  // ----------------------------------------------------------------------------
  always #4 hclk = ~hclk;

  // The whole run needs some 5000 cycles; a hang ends it as a failure.
  initial
  begin
    repeat (60000) @(posedge hclk);
    fail_count++;
    stop_test();
  end

  // Logs every request and trigger with its cycle, and any lit indicator in external mode.
  always @(posedge hclk)
  begin
    cyc <= cyc + 1;
    if (meas_req.req === 1'b1)
    begin
      q_ch.push_back(meas_req.chan2);
      q_t.push_back(cyc);
    end
    if (out_trigger === 1'b1)
      q_tt.push_back(cyc);
    if (ext_mode && (chan1_indicator !== 1'b0 || chan2_indicator !== 1'b0))
      ind_bad <= ind_bad + 1;
  end

  // ----------------------------------------------------------------------------
  // Shared tasks.
  // ----------------------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      $display("Error %s expected %h seen %h", name, exp, seen);
      fail_count++;
    end
  endtask

  // One single AHB transfer: address phase, then data phase, each held until hready.
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= wr;
    htrans <= 2'b10;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] unused;
    bus(1'b1, a, d, unused);
  endtask

  task automatic rd_chk(input string name, input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] v;
    bus(1'b0, a, 32'h0000_0000, v);
    check(name, v, exp);
  endtask

  function automatic logic [31:0] cfg(logic [1:0] src, logic ext, logic dly, logic [9:0] n);
    return {6'h00, n, 12'h000, dly, ext, src};
  endfunction

  task automatic wait_idle();
    int n;
    n = 0;
    repeat (4) @(posedge hclk);
    while (scan_active !== 1'b0 && n < 20000)
    begin
      @(posedge hclk);
      n++;
    end
    check("scan_active", {31'h0, scan_active}, 32'h0000_0000);
  endtask

  // Programs a scan, starts it and clears the record.
  task automatic launch(input logic [31:0] c, input logic [31:0] cycles);
    wr(`REG_CFG, c);
    wr(`REG_CYCLES, cycles);
    q_ch.delete();
    q_t.delete();
    q_tt.delete();
    wr(`REG_CTRL, 32'h0000_0001);
  endtask

  // ----------------------------------------------------------------------------
  // Scenarios.
  // ----------------------------------------------------------------------------
  task automatic t_reset();
    check("hresp", {31'h0, hresp}, 32'h0000_0000);
    check("out_trigger", {31'h0, out_trigger}, 32'h0000_0000);
    rd_chk("unmapped", 12'h040, 32'h0000_0000);
    rd_chk("rd_count", `REG_RD_COUNT, 32'h0000_0000);
  endtask

  task automatic t_immediate();
    lat = 8'h02;
    launch(cfg(SRC_IMMEDIATE, 1'b0, 1'b0, 10'h003), 32'h0000_0002);
    repeat (4) @(posedge hclk);
    check("indicators", {30'h0, chan1_indicator, chan2_indicator}, 32'h0000_0001);
    wait_idle();
    check("meas count", q_ch.size(), 8);
    check("manual_trigger_request count", q_tt.size(), 2);
    for (int i = 0; i < 8; i++)
      check("chan2 order", {31'h0, q_ch[i]}, (i % 4 == 0));
    check("manual_trigger_request after last", q_tt[0] > q_t[3] && q_tt[0] < q_t[4], 1);
    rd_chk("status state", `REG_STATUS, {29'h0, ST_IDLE});
    check("idle ind", {30'h0, chan1_indicator, chan2_indicator}, 32'h0000_0000);
    rd_chk("rd_count", `REG_RD_COUNT, 32'h0000_0008);
    rd_chk("last reading", `REG_LAST_RD, 32'h0001_0007);
    for (int i = 0; i < 8; i++)
    begin
      wr(`REG_RD_ADDR, i);
      rd_chk("buffer word", `REG_RD_DATA, {(i % 4 == 0) ? 16'h0002 : 16'h0001, 16'(i)});
    end
  endtask

  task automatic t_timer();
    int t0;
    wr(`REG_TIMER, 32'h0000_00C8);
    launch(cfg(SRC_TIMER, 1'b0, 1'b0, 10'h001), 32'h0000_0002);
    t0 = cyc;
    wait_idle();
    check("first pass", q_t[0] - t0 <= 10, 1);
    check("inner spacing", q_t[1] - q_t[0] < 20, 1);
    check("interval", q_t[2] - q_t[0] >= 195 && q_t[2] - q_t[0] <= 230, 1);
    lat = 8'h1E;
    wr(`REG_TIMER, 32'h0000_000A);
    launch(cfg(SRC_TIMER, 1'b0, 1'b0, 10'h001), 32'h0000_0002);
    wait_idle();
    check("expired pass", q_t[2] - q_t[1] <= 40, 1);
    lat = 8'h02;
  endtask

  task automatic t_delay();
    int t0;
    wr(`REG_DELAY, 32'h0000_0032);
    launch(cfg(SRC_IMMEDIATE, 1'b0, 1'b1, 10'h001), 32'h0000_0001);
    t0 = cyc;
    wait_idle();
    check("delay first", q_t[0] - t0 >= 50 && q_t[0] - t0 <= 65, 1);
    check("delay loop", q_t[1] - q_t[0] >= 50, 1);
  endtask

  task automatic t_external();
    launch(cfg(SRC_EXTERNAL, 1'b1, 1'b0, 10'h003), 32'h0000_0002);
    ext_mode = 1'b1;
    repeat (30) @(posedge hclk);
    check("armed", q_ch.size(), 0);
    kick <= 1'b1;
    @(posedge hclk);
    kick <= 1'b0;
    repeat (20) @(posedge hclk);
    check("ext manual_trigger_request meas", q_ch.size(), 1);
    wr(`REG_CTRL, 32'h0000_0004);
    wait_idle();
    ext_mode = 1'b0;
    check("manual meas", q_ch.size(), 2);
    check("no chan2", {31'h0, q_ch[0] | q_ch[1]}, 0);
    check("ext manual_trigger_request out", q_tt.size(), 2);
    check("indicators", ind_bad, 0);
  endtask

  task automatic t_max();
    int c2;
    lat = 8'h00;
    launch(cfg(SRC_IMMEDIATE, 1'b0, 1'b0, 10'h3FF), 32'h0000_0001);
    wait_idle();
    c2 = 0;
    foreach (q_ch[i])
      c2 += q_ch[i];
    check("max count", q_ch.size(), 1024);
    check("max chan2", c2, 1);
    check("max manual_trigger_request", q_tt.size(), 1);
    rd_chk("max stored", `REG_RD_COUNT, 32'h0000_0400);
  endtask

  task automatic t_halt();
    int n;
    lat = 8'h28;
    launch(cfg(SRC_IMMEDIATE, 1'b0, 1'b0, 10'h00A), 32'h0000_0003);
    repeat (100) @(posedge hclk);
    wr(`REG_CTRL, 32'h0000_0002);
    repeat (10) @(posedge hclk);
    check("halt", {31'h0, scan_active}, 0);
    n = q_ch.size();
    repeat (100) @(posedge hclk);
    check("halt quiet", q_ch.size(), n);
    lat = 8'h02;
    launch(cfg(SRC_IMMEDIATE, 1'b0, 1'b0, 10'h001), 32'h0000_0001);
    wait_idle();
    check("restart", q_ch.size(), 2);
  endtask

  task automatic stop_test();
    if (fail_count == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Reset, then each scenario in turn.
  initial
  begin
    hclk     = 1'b0;
    hresetn  = 1'b0;
    hsel     = 1'b0;
    haddr    = 12'h000;
    htrans   = 2'b00;
    hwrite   = 1'b0;
    hsize    = 3'b010;
    hwdata   = 32'h0000_0000;
    lat      = 8'h02;
    kick     = 1'b0;
    ext_mode = 1'b0;
    cyc      = 0;
    ind_bad  = 0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_immediate();
    t_timer();
    t_delay();
    t_external();
    t_max();
    t_halt();
    stop_test();
  end
endmodule
